// ### ccdafe_map.svh
`ifndef CCDAFE_MAP_SVH
`define CCDAFE_MAP_SVH
// ==========================================================================
// register addresses
`define CCDAFE_ADDR_OPER 4'h0
`define CCDAFE_ADDR_CTRL 4'h1
`define CCDAFE_ADDR_CLAMP 4'h2
`define CCDAFE_ADDR_GAIN 4'h3
`define CCDAFE_ADDR_START 4'hD
// ==========================================================================
// field positions
`define CCDAFE_OPER_SWRST 0
`define CCDAFE_OPER_CLAMP_OFF 3
`define CCDAFE_OPER_BLK_LEVEL 6
`define CCDAFE_CTRL_CLP_POL 2
`define CCDAFE_CTRL_BLK_POL 3
`define CCDAFE_CTRL_TRISTATE 4
`define CCDAFE_CTRL_GRAY 6
// ==========================================================================
// reset values and constants
`define CCDAFE_RST_WORD 12'h000
`define CCDAFE_RST_CLAMP 12'h080
`define CCDAFE_START_VALUE 12'h838
`define CCDAFE_FRAME_BITS 16
`define CCDAFE_LATENCY 9
`define CCDAFE_GAIN_STEP_UDB 35
`define CCDAFE_GAIN_OFS_MDB 5300
`define CCDAFE_POR_TIME_NS 1000000
`define CCDAFE_CLK_PERIOD_NS 100
`define CCDAFE_POR_CYCLES (`CCDAFE_POR_TIME_NS / `CCDAFE_CLK_PERIOD_NS)
`endif

// ### ccdafe_pkg.sv
package ccdafe_pkg;
    typedef struct packed {
        logic [3:0] addr;
        logic [11:0] data;
    } ccdafe_wr_t;
    typedef struct packed {
        logic [11:0] oper;
        logic [11:0] ctrl;
        logic [7:0] clamp;
        logic [9:0] gain;
        logic [11:0] start;
    } ccdafe_regs_t;
    typedef enum logic [1:0] {
        ST_POR,
        ST_CAL,
        ST_RUN
    } ccdafe_state_t;
endpackage

// ### ccdafe_fifo.sv
module ccdafe_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // fill side
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic wr_valid_in,
    output logic wr_ready_out,
    // drain side
    output logic [WIDTH-1:0] rd_data_out,
    output logic rd_valid_out,
    input wire logic rd_ready_in
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [WIDTH-1:0] mem_nxt [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0] cnt_r, cnt_nxt;
    logic do_wr, do_rd;

    assign wr_ready_out = (cnt_r != (AW+1)'(DEPTH));
    assign rd_valid_out = (cnt_r != '0);
    assign rd_data_out = mem_r[rp_r];
    assign do_wr = wr_valid_in && wr_ready_out;
    assign do_rd = rd_valid_out && rd_ready_in;

    always_comb begin
        mem_nxt = mem_r;
        wp_nxt = wp_r;
        rp_nxt = rp_r;
        cnt_nxt = cnt_r;
        if (do_wr) begin
            mem_nxt[wp_r] = wr_data_in;
            wp_nxt = (wp_r == AW'(DEPTH - 1)) ? '0 : wp_r + AW'(1);
        end
        if (do_rd) begin
            rp_nxt = (rp_r == AW'(DEPTH - 1)) ? '0 : rp_r + AW'(1);
        end
        if (do_wr && !do_rd) begin
            cnt_nxt = cnt_r + (AW+1)'(1);
        end else if (do_rd && !do_wr) begin
            cnt_nxt = cnt_r - (AW+1)'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        mem_r <= mem_nxt;
        if (srst_in) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ### ccdafe_serial.sv
`include "ccdafe_map.svh"
// serial shift port, runs on the link (shift) clock; frames are 4 addr bits then one or more 12-bit data words.
// the strobe is low during a frame; every complete 12-bit word after the address
// is handed over with an auto-incremented address through a toggle handshake.
module ccdafe_serial (
    // reset, system domain, applied while the shift clock is idle
    input wire logic srst_in,
    // link side
    input wire logic sck_in,
    input wire logic serial_load_strobe_in,
    input wire logic serial_data_line_in,
    // capture outputs, sck domain
    output ccdafe_pkg::ccdafe_wr_t word_out,
    output logic word_tgl_out
);
    logic [15:0] shreg_r, shreg_nxt;
    logic [4:0] cnt_r, cnt_nxt;
    logic [3:0] addr_r, addr_nxt;
    logic addr_ok_r, addr_ok_nxt;
    ccdafe_pkg::ccdafe_wr_t word_r, word_nxt;
    logic tgl_r, tgl_nxt;

    assign word_out = word_r;
    assign word_tgl_out = tgl_r;

    // the strobe high marks idle and clears the framing state at once
    always_comb begin
        shreg_nxt = {shreg_r[14:0], serial_data_line_in};
        cnt_nxt = cnt_r + 5'h01;
        addr_nxt = addr_r;
        addr_ok_nxt = addr_ok_r;
        word_nxt = word_r;
        tgl_nxt = tgl_r;
        if (!addr_ok_r && cnt_r == 5'h03) begin
            addr_nxt = shreg_nxt[3:0];
            addr_ok_nxt = 1'b1;
            cnt_nxt = 5'h00;
        end else if (addr_ok_r && cnt_r == 5'h0B) begin
            word_nxt.addr = addr_r;
            word_nxt.data = shreg_nxt[11:0];
            tgl_nxt = ~tgl_r;
            addr_nxt = addr_r + 4'h1;
            cnt_nxt = 5'h00;
        end
    end

    // the shift clock stops between frames, so the strobe clears framing itself
    always_ff @(posedge sck_in or posedge serial_load_strobe_in) begin
        if (serial_load_strobe_in) begin
            cnt_r <= 5'h00;
            addr_ok_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            addr_ok_r <= addr_ok_nxt;
        end
    end

    // the toggle needs a known start for the crossing; no shift clock runs in reset
    always_ff @(posedge sck_in or posedge srst_in) begin
        if (srst_in) begin
            tgl_r <= 1'b0;
        end else begin
            tgl_r <= tgl_nxt;
        end
    end

    always_ff @(posedge sck_in) begin
        shreg_r <= shreg_nxt;
        addr_r <= addr_nxt;
        word_r <= word_nxt;
    end
endmodule

// ### ccdafe_top.sv
`include "ccdafe_map.svh"
module ccdafe_top #(
    parameter int POR_CYCLES = `CCDAFE_POR_CYCLES,
    parameter int DATA_W = 12,
    parameter int FIFO_DEPTH = 8
) (
    // system
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // serial programming link
    input wire logic sck_in,
    input wire logic serial_load_strobe_in,
    input wire logic serial_data_line_in,
    // timing pulses and samples (sys_clk acts as output data clock)
    input wire logic black_clamp_pulse_in,
    input wire logic blanking_pulse_in,
    input wire logic sample_valid_in,
    input wire logic [DATA_W-1:0] sample_in,
    // output data
    output logic [DATA_W-1:0] data_out,
    output logic [DATA_W-1:0] data_oe_n_out,
    output logic data_valid_out,
    input wire logic data_ready_in,
    // clamp and gain to the analog chain, and the ready flag
    output logic clamp_active_out,
    output logic [7:0] clamp_level_out,
    output logic [9:0] gain_code_out,
    output logic [19:0] gain_mdb_out,
    output logic ready_out
);
    // ======================================================================
    // serial link and crossing
    ccdafe_pkg::ccdafe_wr_t lk_word;
    logic lk_tgl;
    ccdafe_serial u_serial (
        .srst_in(srst_in),
        .sck_in(sck_in),
        .serial_load_strobe_in(serial_load_strobe_in),
        .serial_data_line_in(serial_data_line_in),
        .word_out(lk_word),
        .word_tgl_out(lk_tgl)
    );

    logic tgl_s1_r, tgl_s2_r, tgl_s3_r;
    logic sl_s1_r, sl_s2_r, sl_s3_r;
    logic sl_s4_r;
    logic clp_s1_r, clp_s2_r, blk_s1_r, blk_s2_r;
    ccdafe_pkg::ccdafe_wr_t hold_r [16];
    ccdafe_pkg::ccdafe_wr_t hold_nxt [16];
    logic [15:0] pend_r, pend_nxt;

    // pin synchronisers; the toggle is stable for at least 12 shift clocks, so
    // the word beside it is settled when the edge is seen
    always_ff @(posedge sys_clk_in) begin
        tgl_s1_r <= lk_tgl;
        tgl_s2_r <= tgl_s1_r;
        tgl_s3_r <= tgl_s2_r;
        sl_s1_r <= serial_load_strobe_in;
        sl_s2_r <= sl_s1_r;
        sl_s3_r <= sl_s2_r;
        sl_s4_r <= sl_s3_r;
        clp_s1_r <= black_clamp_pulse_in;
        clp_s2_r <= clp_s1_r;
        blk_s1_r <= blanking_pulse_in;
        blk_s2_r <= blk_s1_r;
    end

    // ======================================================================
    // power-on reset and calibration
    ccdafe_pkg::ccdafe_state_t st_r, st_nxt;
    logic [$clog2(POR_CYCLES+1)-1:0] por_cnt_r, por_cnt_nxt;

    always_comb begin
        st_nxt = st_r;
        por_cnt_nxt = por_cnt_r;
        case (st_r)
            ccdafe_pkg::ST_POR: begin
                por_cnt_nxt = '0;
                st_nxt = ccdafe_pkg::ST_CAL;
            end
            ccdafe_pkg::ST_CAL: begin
                por_cnt_nxt = por_cnt_r + 1'b1;
                if (por_cnt_r == $bits(por_cnt_r)'(POR_CYCLES - 1)) begin
                    st_nxt = ccdafe_pkg::ST_RUN;
                end
            end
            ccdafe_pkg::ST_RUN: begin
                st_nxt = ccdafe_pkg::ST_RUN;
            end
            default: begin
                st_nxt = ccdafe_pkg::ST_POR;
            end
        endcase
    end

    always_ff @(posedge sys_clk_in) begin
        if (srst_in) begin
            st_r <= ccdafe_pkg::ST_POR;
            por_cnt_r <= '0;
        end else begin
            st_r <= st_nxt;
            por_cnt_r <= por_cnt_nxt;
        end
    end

    // ======================================================================
    // registers: words staged on arrival, applied on strobe rise
    ccdafe_pkg::ccdafe_regs_t regs_r, regs_nxt;
    logic word_evt, load_evt, running;
    assign word_evt = tgl_s2_r ^ tgl_s3_r;
    // the strobe can rise within one system clock of the last word's toggle;
    // one extra stage keeps the load strictly after that word is staged
    assign load_evt = sl_s3_r && !sl_s4_r;
    assign running = (st_r == ccdafe_pkg::ST_RUN);

    localparam ccdafe_pkg::ccdafe_regs_t REGS_RST = '{
        oper: `CCDAFE_RST_WORD,
        ctrl: `CCDAFE_RST_WORD,
        clamp: 8'(`CCDAFE_RST_CLAMP),
        gain: 10'(`CCDAFE_RST_WORD),
        start: `CCDAFE_RST_WORD
    };

    always_comb begin
        hold_nxt = hold_r;
        pend_nxt = pend_r;
        regs_nxt = regs_r;
        if (word_evt && running) begin
            hold_nxt[lk_word.addr] = lk_word;
            pend_nxt[lk_word.addr] = 1'b1;
        end
        if (load_evt && running) begin
            pend_nxt = '0;
            if (pend_r[`CCDAFE_ADDR_OPER]) begin
                regs_nxt.oper = hold_r[`CCDAFE_ADDR_OPER].data;
            end
            if (pend_r[`CCDAFE_ADDR_CTRL]) begin
                regs_nxt.ctrl = hold_r[`CCDAFE_ADDR_CTRL].data;
            end
            if (pend_r[`CCDAFE_ADDR_CLAMP]) begin
                regs_nxt.clamp = hold_r[`CCDAFE_ADDR_CLAMP].data[7:0];
            end
            if (pend_r[`CCDAFE_ADDR_GAIN]) begin
                regs_nxt.gain = hold_r[`CCDAFE_ADDR_GAIN].data[9:0];
            end
            if (pend_r[`CCDAFE_ADDR_START]) begin
                regs_nxt.start = hold_r[`CCDAFE_ADDR_START].data;
            end
        end
        // soft reset clears itself on the following cycle
        if (regs_r.oper[`CCDAFE_OPER_SWRST]) begin
            regs_nxt = REGS_RST;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        hold_r <= hold_nxt;
        if (srst_in || !running) begin
            regs_r <= REGS_RST;
            pend_r <= '0;
        end else begin
            regs_r <= regs_nxt;
            pend_r <= pend_nxt;
        end
    end

    // ======================================================================
    // clamp/blank decode and latency pipeline
    localparam int PW = DATA_W + 1;
    logic clp_act, blk_act, blk_eff;
    logic [PW-1:0] pipe_r [`CCDAFE_LATENCY];
    logic [PW-1:0] pipe_nxt [`CCDAFE_LATENCY];
    logic [`CCDAFE_LATENCY-1:0] pv_r, pv_nxt;
    logic fifo_ready, fifo_valid;
    logic [DATA_W-1:0] fifo_data;
    logic adv;

    assign clp_act = ~(clp_s2_r ^ regs_r.ctrl[`CCDAFE_CTRL_CLP_POL]);
    assign blk_act = ~(blk_s2_r ^ regs_r.ctrl[`CCDAFE_CTRL_BLK_POL]);
    assign blk_eff = blk_act && !clp_act;
    // pipeline stalls when the fifo cannot take the leaving word
    assign adv = fifo_ready || !pv_r[`CCDAFE_LATENCY-1];

    always_comb begin
        pipe_nxt = pipe_r;
        pv_nxt = pv_r;
        if (adv) begin
            pipe_nxt[0] = {blk_eff, sample_in};
            pv_nxt[0] = sample_valid_in;
            for (int i = 1; i < `CCDAFE_LATENCY; i++) begin
                pipe_nxt[i] = pipe_r[i-1];
                pv_nxt[i] = pv_r[i-1];
            end
        end
    end

    logic [DATA_W-1:0] out_word;
    always_comb begin
        out_word = pipe_r[`CCDAFE_LATENCY-1][DATA_W-1:0];
        if (pipe_r[`CCDAFE_LATENCY-1][DATA_W]) begin
            out_word = regs_r.oper[`CCDAFE_OPER_BLK_LEVEL] ?
                       DATA_W'(regs_r.clamp) : '0;
        end
        if (regs_r.ctrl[`CCDAFE_CTRL_GRAY]) begin
            out_word = out_word ^ (out_word >> 1);
        end
    end

    always_ff @(posedge sys_clk_in) begin
        pipe_r <= pipe_nxt;
        if (srst_in) begin
            pv_r <= '0;
        end else begin
            pv_r <= pv_nxt;
        end
    end

    ccdafe_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_in(sys_clk_in),
        .srst_in(srst_in),
        .wr_data_in(out_word),
        .wr_valid_in(pv_r[`CCDAFE_LATENCY-1] && adv),
        .wr_ready_out(fifo_ready),
        .rd_data_out(fifo_data),
        .rd_valid_out(fifo_valid),
        .rd_ready_in(!data_valid_out || data_ready_in)
    );

    // ======================================================================
    // registered outputs
    logic [19:0] gain_mdb;
    logic [DATA_W-1:0] data_nxt;
    logic [DATA_W-1:0] data_oe_n_nxt;
    logic data_valid_nxt;
    logic clamp_active_nxt;
    logic [7:0] clamp_level_nxt;
    logic [9:0] gain_code_nxt;
    logic [19:0] gain_mdb_nxt;
    logic ready_nxt;
    logic out_take;
    assign gain_mdb = 20'(regs_r.gain) * 20'(`CCDAFE_GAIN_STEP_UDB)
                      + 20'(`CCDAFE_GAIN_OFS_MDB);
    // a held word moves on only once the sink has taken it
    assign out_take = !data_valid_out || data_ready_in;

    always_comb begin
        data_nxt = data_out;
        data_valid_nxt = data_valid_out;
        data_oe_n_nxt = {DATA_W{regs_r.ctrl[`CCDAFE_CTRL_TRISTATE]}};
        clamp_active_nxt = clp_act && !regs_r.oper[`CCDAFE_OPER_CLAMP_OFF];
        clamp_level_nxt = regs_r.clamp;
        gain_code_nxt = regs_r.gain;
        gain_mdb_nxt = gain_mdb;
        ready_nxt = running;
        if (out_take) begin
            data_nxt = fifo_data;
            data_valid_nxt = fifo_valid;
        end
        if (srst_in) begin
            data_nxt = '0;
            data_valid_nxt = 1'b0;
            data_oe_n_nxt = '1;
            clamp_active_nxt = 1'b0;
            clamp_level_nxt = 8'(`CCDAFE_RST_CLAMP);
            gain_code_nxt = '0;
            gain_mdb_nxt = 20'(`CCDAFE_GAIN_OFS_MDB);
            ready_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk_in) begin
        data_out <= data_nxt;
        data_valid_out <= data_valid_nxt;
        data_oe_n_out <= data_oe_n_nxt;
        clamp_active_out <= clamp_active_nxt;
        clamp_level_out <= clamp_level_nxt;
        gain_code_out <= gain_code_nxt;
        gain_mdb_out <= gain_mdb_nxt;
        ready_out <= ready_nxt;
    end
endmodule

// ### ccdafe_sva.sv
module ccdafe_sva #(
    parameter int POR_CYCLES = 20,
    parameter int DATA_W = 12
) (
    // system
    input wire logic sys_clk_in,
    input wire logic srst_in,
    // watched inputs
    input wire logic serial_load_strobe_in,
    input wire logic sample_valid_in,
    input wire logic data_ready_in,
    // watched outputs
    input wire logic [DATA_W-1:0] data_out,
    input wire logic data_valid_out,
    input wire logic [7:0] clamp_level_out,
    input wire logic [9:0] gain_code_out,
    input wire logic [19:0] gain_mdb_out,
    input wire logic ready_out
);
    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (srst_in);
    int por_cnt_r;
    int por_cnt_nxt;
    // cycles since reset release, frozen once ready
    always_comb por_cnt_nxt = srst_in ? 0 : (ready_out ? por_cnt_r : por_cnt_r + 1);
    always_ff @(posedge sys_clk_in) por_cnt_r <= por_cnt_nxt;
    sequence word_held;
        data_valid_out && $stable(data_out);
    endsequence
    sequence sampled_earlier;
        $past(sample_valid_in, 10) || $past(sample_valid_in, 11) || $past(sample_valid_in, 12);
    endsequence
    gain_map_a: assert property ($stable(gain_code_out) |->
        gain_mdb_out == 20'(gain_code_out) * 20'h00023 + 20'h014B4)
        else $error("gain in db does not follow the code");
    gain_range_a: assert property (gain_mdb_out inside {[20'h014B4:20'h0A091]})
        else $error("gain outside its range");
    reset_vals_a: assert property ($fell(srst_in) |-> clamp_level_out == 8'h80 &&
        gain_code_out == 10'h000 && !ready_out && !data_valid_out)
        else $error("wrong reset values");
    por_held_a: assert property (!ready_out |-> clamp_level_out == 8'h80 &&
        gain_code_out == 10'h000) else $error("register changed before calibration end");
    por_time_a: assert property ($rose(ready_out) |->
        por_cnt_r inside {[POR_CYCLES + 1:POR_CYCLES + 3]}) else $error("calibration time wrong");
    ready_stays_a: assert property (ready_out |=> ready_out)
        else $error("ready dropped without reset");
    load_only_a: assert property (!$stable({gain_code_out, clamp_level_out}) |->
        serial_load_strobe_in) else $error("register changed inside a frame");
    data_hold_a: assert property (data_valid_out && !data_ready_in |=> word_held)
        else $error("stalled output word changed");
    out_latency_a: assert property ($rose(data_valid_out) |-> sampled_earlier)
        else $error("output word without matching sample latency");
endmodule

bind ccdafe_top ccdafe_sva #(.POR_CYCLES(POR_CYCLES), .DATA_W(DATA_W)) u_sva (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .serial_load_strobe_in(serial_load_strobe_in),
    .sample_valid_in(sample_valid_in),
    .data_ready_in(data_ready_in),
    .data_out(data_out),
    .data_valid_out(data_valid_out),
    .clamp_level_out(clamp_level_out),
    .gain_code_out(gain_code_out),
    .gain_mdb_out(gain_mdb_out),
    .ready_out(ready_out)
);

// ### ccdafe_ctrl_model.sv
module ccdafe_ctrl_model (
    // serial programming link
    output logic sck_out,
    output logic serial_load_strobe_out,
    output logic serial_data_line_out
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        sck_out = 1'b0;
        serial_load_strobe_out = 1'b1;
        serial_data_line_out = 1'b0;
    end
    // one frame: address then nw words, msb first, shift clock 48 ns only inside
    task automatic send(input logic [3:0] addr, input logic [23:0] words, input int nw);
        logic [27:0] bits;
        bits = {addr, words};
        serial_load_strobe_out = 1'b0;
        for (int i = 27; i >= 24 - 12 * nw; i--) begin
            serial_data_line_out = bits[i];
            #24 sck_out = 1'b1;
            #24 sck_out = 1'b0;
        end
        serial_data_line_out = ~serial_data_line_out;
        #24 serial_load_strobe_out = 1'b1;
        #600;
    endtask
endmodule

// ### ccdafe_top_tb.sv
module ccdafe_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int POR = 20;
    logic sys_clk, srst, sck, strobe, serial_data_line, clamp_p, blank_p, s_valid, ready_in;
    logic d_valid, clamp_act, por_done;
    logic [11:0] sample, data, oe_n;
    logic [7:0] clamp_lvl;
    logic [9:0] gain;
    logic [19:0] gain_mdb;
    logic [11:0] expq[$];
    logic [9:0] gtab[3] = '{10'h000, 10'h3FF, 10'h200};
    logic [3:0] modes[6] = '{4'h0, 4'h1, 4'h9, 4'hB, 4'hD, 4'h8};
    logic [3:0] m;
    int mismatches = 0;
    int total_checks = 0;
    int seed = 32'hDFEEBD2B;
    // ======================================================================
    // clock, parts and helpers
    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end
    ccdafe_ctrl_model model (.sck_out(sck), .serial_load_strobe_out(strobe),
        .serial_data_line_out(serial_data_line));
    ccdafe_top #(.POR_CYCLES(POR)) uut (
        .sys_clk_in(sys_clk), .srst_in(srst), .sck_in(sck),
        .serial_load_strobe_in(strobe), .serial_data_line_in(serial_data_line),
        .black_clamp_pulse_in(clamp_p), .blanking_pulse_in(blank_p),
        .sample_valid_in(s_valid), .sample_in(sample), .data_out(data),
        .data_oe_n_out(oe_n), .data_valid_out(d_valid), .data_ready_in(ready_in),
        .clamp_active_out(clamp_act), .clamp_level_out(clamp_lvl),
        .gain_code_out(gain), .gain_mdb_out(gain_mdb), .ready_out(por_done));
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        total_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    always @(posedge sys_clk) begin
        if (d_valid === 1'b1 && ready_in === 1'b1 && srst === 1'b0) begin
            if (expq.size() == 0) begin
                check(1, 0, "unexpected word");
            end else begin
                check(data, expq.pop_front(), "output word");
            end
        end
    end
    // ======================================================================
    // main sequence
    initial begin
        clamp_p = 1'b1;
        blank_p = 1'b1;
        s_valid = 1'b0;
        sample = 12'h000;
        ready_in = 1'b1;
        // a clean rising reset edge clears the link-side toggle
        srst = 1'b0;
        #1;
        srst = 1'b1;
        repeat (16) @(negedge sys_clk);
        check(clamp_lvl, 8'h80, "clamp reset");
        check(gain_mdb, 20'h014B4, "gain reset");
        srst = 1'b0;
        model.send(4'h3, {12'h155, 12'h000}, 1);
        for (int i = 0; i < 200 && por_done !== 1'b1; i++) @(negedge sys_clk);
        check(por_done, 1, "calibration done");
        check(gain, 0, "write before ready");
        if (por_done !== 1'b1) summarize();
        $display("test power-on done");
        model.send(4'hD, {12'h838, 12'h000}, 1);
        for (int k = 0; k < 3; k++) begin
            model.send(4'h2, {12'h05A, 2'b00, gtab[k]}, 2);
            @(negedge sys_clk);
            check(clamp_lvl, 8'h5A, "clamp level");
            check(gain, gtab[k], "gain code");
            check(gain_mdb, 20'(gtab[k]) * 20'h00023 + 20'h014B4, "gain db");
        end
        $display("test registers done");
        foreach (modes[j]) begin
            m = modes[j];
            model.send(4'h0, {5'h00, m[2], 6'h00, 8'h00, m[3], m[3], 2'b00}, 2);
            @(negedge sys_clk);
            clamp_p = ~(m[3] ^ m[1]);
            blank_p = ~(m[3] ^ m[0]);
            ready_in = 1'b0;
            repeat (4) @(negedge sys_clk);
            check(clamp_act, m[1], "clamp active");
            for (int i = 0; i < 12; i++) begin
                sample = 12'($random(seed));
                s_valid = 1'b1;
                expq.push_back((m[0] && !m[1]) ? {4'h0, m[2] ? 8'h5A : 8'h00} : sample);
                @(negedge sys_clk);
            end
            s_valid = 1'b0;
            // far side stalls until the fifo is full
            repeat (20) @(negedge sys_clk);
            for (int i = 0; i < 400 && expq.size() > 0; i++) begin
                ready_in = 1'($random(seed));
                @(negedge sys_clk);
            end
            check(expq.size(), 0, "words drained");
            if (expq.size() > 0) summarize();
            ready_in = 1'b1;
            $display("test mode %h done", m);
        end
        // gray coding with three-stated outputs, then clamp disable and soft reset
        clamp_p = 1'b1;
        blank_p = 1'b1;
        model.send(4'h1, {12'h050, 12'h000}, 1);
        @(negedge sys_clk);
        check(oe_n, 12'hFFF, "outputs three-stated");
        for (int i = 0; i < 8; i++) begin
            sample = 12'($random(seed));
            s_valid = 1'b1;
            expq.push_back(sample ^ (sample >> 1));
            @(negedge sys_clk);
        end
        s_valid = 1'b0;
        for (int i = 0; i < 100 && expq.size() > 0; i++) @(negedge sys_clk);
        check(expq.size(), 0, "gray words drained");
        if (expq.size() > 0) summarize();
        model.send(4'h0, {12'h008, 12'h000}, 1);
        @(negedge sys_clk);
        clamp_p = 1'b0;
        repeat (4) @(negedge sys_clk);
        check(clamp_act, 0, "clamp disabled");
        model.send(4'h0, {12'h001, 12'h000}, 1);
        @(negedge sys_clk);
        check(clamp_lvl, 8'h80, "soft reset clamp");
        check(oe_n, 12'h000, "soft reset drive");
        check(clamp_act, 1, "soft reset clamp on");
        clamp_p = 1'b1;
        $display("test coding and soft reset done");
        repeat (4) @(negedge sys_clk);
        summarize();
    end
endmodule
